// File: include/eba_cfg.svh
// Notes on behaviour
// [RULE1] high address register bit 0 is the ninth address bit
// [RULE2] a write programs the data register byte at the addressed location
// [RULE3] after a read the data register holds the addressed byte
// [RULE4] ready interrupt stands while enabled, globally enabled and no write runs
// [RULE5] write starts only when strobe is set while master enable is one
// [RULE6] strobe with master enable zero starts nothing
// [RULE7] master enable clears itself four cycles after software sets it
// [RULE8] software: wait idle, wait flash, load, enable, strobe within four
// [RULE9] no programming while flash self-programming is busy
// [RULE10] software keeps interrupts off during the write sequence
// [RULE11] hardware clears the write strobe when the write time has elapsed
// [RULE12] setting the write strobe stalls the processor two cycles
// [RULE13] read strobe fetches the byte at once; strobe reads back zero
// [RULE14] a read stalls the processor four cycles
// [RULE15] during a write, no read and no address change
// [RULE16] software polls write strobe zero before reading
// [RULE17] a write lasts 8448 cycles of the 1 MHz timing clock
// [RULE18] 512 bytes addressed linearly 0 to 511
// [RULE19] write completion passes a synchroniser before clearing the strobe
`ifndef EBA_CFG_SVH
`define EBA_CFG_SVH

// ****************************************
// register offsets in i/o space
// ****************************************
`define EBA_OFS_CONTROL 6'h1c
`define EBA_OFS_DATA 6'h1d
`define EBA_OFS_ADDR_LOW 6'h1e
`define EBA_OFS_ADDR_HIGH 6'h1f

// ****************************************
// control register fields and resets
// ****************************************
`define EBA_BIT_READ_STROBE 0
`define EBA_BIT_WRITE_STROBE 1
`define EBA_BIT_MASTER_WE 2
`define EBA_BIT_READY_IRQ_EN 3
`define EBA_BIT_ADDR_MSB 0
`define EBA_RESET_BYTE 8'h00
`define EBA_RESET_ADDR 9'h000

// ****************************************
// timing
// ****************************************
`define EBA_CLK_PERIOD_NS 10
`define EBA_OSC_PERIOD_NS 1000
`define EBA_OSC_DIV (`EBA_OSC_PERIOD_NS / `EBA_CLK_PERIOD_NS)
`define EBA_WRITE_OSC_CYCLES 8448
`define EBA_WRITE_TIME_US_TYP 8500
`define EBA_MWE_WINDOW 3'h4
`define EBA_STALL_READ 3'h4
`define EBA_STALL_WRITE 3'h2

`endif

// File: include/eba_pkg.sv
package eba_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic we;
    logic re;
    logic [7:0] wdata;
  } eba_io_req_t;

  typedef enum logic [1:0] {
    EBA_W_IDLE = 2'b00,
    EBA_W_PROG = 2'b01,
    EBA_W_SYNC = 2'b10
  } eba_wstate_t;

endpackage

// File: rtl/eba_sync.sv
`timescale 1ns/100ps

// two-flop synchroniser; first stage feeds only the second
module eba_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);

  logic meta;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // eba_sync

// File: rtl/eba_array.sv
`timescale 1ns/100ps

// 512 byte cell array: clocked write, immediate read
module eba_array (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [8:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [8:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] cells [0:511];

  // cells hold no reset, like the real nonvolatile store
  always_ff @(posedge clk)
  begin
    if (wr_en)
      cells[wr_addr] <= wr_data;
  end

  assign rd_data = cells[rd_addr];

endmodule // eba_array

// File: rtl/eba_ctrl.sv
`timescale 1ns/100ps
`include "eba_cfg.svh"

module eba_ctrl #(
  parameter int unsigned WRITE_OSC_CYCLES = `EBA_WRITE_OSC_CYCLES,
  parameter int unsigned OSC_DIV = `EBA_OSC_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire eba_pkg::eba_io_req_t io_req,
  input wire logic global_irq_en,
  input wire logic flash_selfprog_busy,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq
);

  // ****************************************
  // register decode
  // ****************************************
  logic ready_irq_enable;
  logic master_write_enable;
  logic [2:0] mwe_cnt;
  logic [7:0] nvm_data_reg;
  logic [8:0] nvm_addr_reg;
  logic [8:0] prog_addr;
  logic [7:0] prog_data;
  logic [2:0] stall_cnt;
  logic [6:0] osc_div_cnt;
  logic [13:0] osc_cnt;
  logic done_tgl;
  logic done_sync;
  logic done_prev;
  eba_pkg::eba_wstate_t wstate;
  eba_pkg::eba_wstate_t next_wstate;

  wire wr_access = io_req.we;
  wire ctrl_wr = wr_access && (io_req.addr == `EBA_OFS_CONTROL);
  wire data_wr = wr_access && (io_req.addr == `EBA_OFS_DATA);
  wire addr_lo_wr = wr_access && (io_req.addr == `EBA_OFS_ADDR_LOW);
  wire addr_hi_wr = wr_access && (io_req.addr == `EBA_OFS_ADDR_HIGH);
  wire write_strobe = (wstate != eba_pkg::EBA_W_IDLE);
  wire mwe_set = ctrl_wr && io_req.wdata[`EBA_BIT_MASTER_WE];
  wire ws_req = ctrl_wr && io_req.wdata[`EBA_BIT_WRITE_STROBE];
  wire rs_req = ctrl_wr && io_req.wdata[`EBA_BIT_READ_STROBE];
  // flash self-programming blocks a new write outright
  wire wr_go = ws_req && master_write_enable && !write_strobe //RULE5 RULE6
    && !flash_selfprog_busy; //RULE9
  wire rd_go = rs_req && !write_strobe && !wr_go; //RULE15
  wire addr_lock = write_strobe; //RULE15
  wire osc_tick = (osc_div_cnt == 7'(OSC_DIV - 1));
  wire prog_done = osc_tick && (osc_cnt == 14'(WRITE_OSC_CYCLES - 1));
  wire done_evt = done_sync ^ done_prev;
  wire [7:0] cell_rd;

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] ctrl_view = {4'h0, ready_irq_enable, master_write_enable,
    write_strobe, 1'b0}; //RULE13
  wire [7:0] addr_hi_view = {7'h00, nvm_addr_reg[8]}; //RULE1
  wire [7:0] next_rdata =
    (io_req.addr == `EBA_OFS_CONTROL) ? ctrl_view :
    (io_req.addr == `EBA_OFS_DATA) ? nvm_data_reg :
    (io_req.addr == `EBA_OFS_ADDR_LOW) ? nvm_addr_reg[7:0] :
    (io_req.addr == `EBA_OFS_ADDR_HIGH) ? addr_hi_view : 8'h00;

  wire [2:0] next_stall_cnt = wr_go ? `EBA_STALL_WRITE : //RULE12
    rd_go ? `EBA_STALL_READ : //RULE14
    (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
  wire next_irq = ready_irq_enable && global_irq_en && !write_strobe; //RULE4

  // ****************************************
  // cell array and completion crossing
  // ****************************************
  eba_array u_array (
    .clk(clk),
    .wr_en(done_evt && wstate == eba_pkg::EBA_W_SYNC), //RULE2
    .wr_addr(prog_addr),
    .wr_data(prog_data),
    .rd_addr(nvm_addr_reg), //RULE18
    .rd_data(cell_rd)
  );

  // completion is a toggle so a stale level can never end the next write
  eba_sync u_done_sync (
    .clk(clk),
    .rstn(rstn),
    .d(done_tgl),
    .q(done_sync) //RULE19
  );

  // ****************************************
  // write sequencer
  // ****************************************
  always_comb
  begin
    next_wstate = wstate;
    case (wstate)
      eba_pkg::EBA_W_IDLE:
        if (wr_go)
          next_wstate = eba_pkg::EBA_W_PROG;
      eba_pkg::EBA_W_PROG:
        if (prog_done)
          next_wstate = eba_pkg::EBA_W_SYNC;
      eba_pkg::EBA_W_SYNC:
        if (done_evt)
          next_wstate = eba_pkg::EBA_W_IDLE; //RULE11
      default:
        next_wstate = eba_pkg::EBA_W_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wstate <= eba_pkg::EBA_W_IDLE;
    else
      wstate <= next_wstate;
  end

  // 1 MHz timing enable: free-running divider of the cpu clock
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_div_cnt <= 7'h00;
    else
      osc_div_cnt <= osc_tick ? 7'h00 : osc_div_cnt + 7'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_cnt <= 14'h0000;
      done_tgl <= 1'b0;
    end
    else if (wstate != eba_pkg::EBA_W_PROG)
      osc_cnt <= 14'h0000;
    else if (osc_tick)
    begin
      osc_cnt <= osc_cnt + 14'h0001; //RULE17
      if (prog_done)
        done_tgl <= !done_tgl; //RULE19
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      done_prev <= 1'b0;
    else
      done_prev <= done_sync;
  end

  // byte and address are latched so later register writes cannot corrupt it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_addr <= `EBA_RESET_ADDR;
      prog_data <= `EBA_RESET_BYTE;
    end
    else if (wr_go)
    begin
      prog_addr <= nvm_addr_reg; //RULE2
      prog_data <= nvm_data_reg; //RULE2
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ready_irq_enable <= 1'b0;
      master_write_enable <= 1'b0;
      mwe_cnt <= 3'h0;
    end
    else if (ctrl_wr)
    begin
      ready_irq_enable <= io_req.wdata[`EBA_BIT_READY_IRQ_EN];
      master_write_enable <= mwe_set;
      mwe_cnt <= mwe_set ? `EBA_MWE_WINDOW : 3'h0;
    end
    else if (mwe_cnt != 3'h0)
    begin
      mwe_cnt <= mwe_cnt - 3'h1;
      if (mwe_cnt == 3'h1)
        master_write_enable <= 1'b0; //RULE7
    end
  end

  // address power-up is undefined; zero is chosen for determinism
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      nvm_addr_reg <= `EBA_RESET_ADDR;
    else if (addr_lo_wr && !addr_lock)
      nvm_addr_reg[7:0] <= io_req.wdata;
    else if (addr_hi_wr && !addr_lock)
      nvm_addr_reg[8] <= io_req.wdata[`EBA_BIT_ADDR_MSB]; //RULE1
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      nvm_data_reg <= `EBA_RESET_BYTE;
    else if (rd_go)
      nvm_data_reg <= cell_rd; //RULE3 RULE13
    else if (data_wr)
      nvm_data_reg <= io_req.wdata;
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_rdata <= 8'h00;
      stall_cnt <= 3'h0;
      cpu_stall <= 1'b0;
      ready_irq <= 1'b0;
    end
    else
    begin
      if (io_req.re)
        io_rdata <= next_rdata;
      stall_cnt <= next_stall_cnt;
      cpu_stall <= (next_stall_cnt != 3'h0);
      ready_irq <= next_irq;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a later control write may legally cancel the window, so it ends the check
  sequence s_mwe_window;
    mwe_set ##1 (!ctrl_wr) [*3];
  endsequence

  sequence s_write_stall;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  sequence s_read_stall;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  a_mwe_hold_window: assert property ( //RULE7
    s_mwe_window |=> master_write_enable)
    else $error("master enable did not hold four cycles");

  a_mwe_auto_clear: assert property ( //RULE7
    (mwe_cnt == 3'h1 && !ctrl_wr) |=> !master_write_enable)
    else $error("master enable not cleared after window");

  a_strobe_gated: assert property ( //RULE6
    (ws_req && !master_write_enable && !write_strobe) |=> !write_strobe)
    else $error("write started without master enable");

  a_flash_blocks: assert property ( //RULE9
    (ws_req && flash_selfprog_busy && !write_strobe) |=> !write_strobe)
    else $error("write started during flash programming");

  a_write_starts: assert property ( //RULE5
    (ws_req && master_write_enable && !write_strobe
      && !flash_selfprog_busy) |=> write_strobe ##0 s_write_stall)
    else $error("valid write strobe did not start a write");

  a_read_stall: assert property ( //RULE14
    rd_go |=> s_read_stall)
    else $error("read stall not four cycles");

  a_read_data: assert property ( //RULE3
    rd_go |=> (nvm_data_reg == $past(cell_rd)))
    else $error("read byte not in data register");

  a_addr_locked: assert property ( //RULE15
    write_strobe |=> $stable(nvm_addr_reg))
    else $error("address changed during write");

  a_no_read_busy: assert property ( //RULE15
    (rs_req && write_strobe) |=> $stable(nvm_data_reg) || $past(data_wr))
    else $error("read performed during write");

  a_irq_level: assert property ( //RULE4
    (ready_irq_enable && global_irq_en && !write_strobe) [*2]
      |-> ready_irq)
    else $error("ready interrupt missing");

  a_irq_busy: assert property ( //RULE4
    $past(write_strobe) |-> !ready_irq)
    else $error("ready interrupt during write");

  a_done_clears: assert property ( //RULE11
    (wstate == eba_pkg::EBA_W_PROG && prog_done) |-> ##[3:4] !write_strobe)
    else $error("write strobe not cleared after timing");

endmodule // eba_ctrl

// File: test/tb.sv
`timescale 1ns/100ps

module tb;
  // ****************************
  // bench signals
  // ****************************
  localparam int WOC = 4;
  localparam int ODIV = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  eba_pkg::eba_io_req_t io_req = '0;
  logic global_irq_en = 1'b0;
  logic flash_selfprog_busy = 1'b0;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  logic [7:0] ien = 8'h00;
  logic [7:0] rv;
  int err_total = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  // shortened write time keeps the run small; bounds below derive from it
  eba_ctrl #(.WRITE_OSC_CYCLES(WOC), .OSC_DIV(ODIV)) dut_u (
    .clk(clk),
    .rstn(rstn),
    .io_req(io_req),
    .global_irq_en(global_irq_en),
    .flash_selfprog_busy(flash_selfprog_busy),
    .io_rdata(io_rdata),
    .cpu_stall(cpu_stall),
    .ready_irq(ready_irq)
  );

  // ****************************
  // shared tasks
  // ****************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up();
    err_total++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 8'hff, 8'h00);
    test_done();
  endtask

  // one idle edge after each access so a strobe is never set twice at once
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req.addr <= a;
    io_req.wdata <= d;
    io_req.we <= 1'b1;
    @(posedge clk);
    io_req.we <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req.addr <= a;
    io_req.re <= 1'b1;
    @(posedge clk);
    io_req.re <= 1'b0;
    @(posedge clk);
    #1;
    d = io_rdata;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 100; i++)
    begin
      rd(6'h1c, rv);
      if (rv[1] === 1'b0)
        return;
    end
    give_up();
  endtask

  task automatic prog(input logic [8:0] a, input logic [7:0] d,
                      input int gap);
    wr(6'h1f, {7'h00, a[8]});
    wr(6'h1e, a[7:0]);
    wr(6'h1d, d);
    wr(6'h1c, ien | 8'h04);
    repeat (gap) @(posedge clk);
    wr(6'h1c, ien | 8'h02);
  endtask

  task automatic fetch(input logic [8:0] a, output logic [7:0] d);
    wr(6'h1f, {7'h00, a[8]});
    wr(6'h1e, a[7:0]);
    wr(6'h1c, ien | 8'h01);
    rd(6'h1d, d);
  endtask

  task automatic count_stall(output int n);
    n = 0;
    // the stall rises at the edge that took the strobe, so look at once
    repeat (8)
    begin
      #1;
      if (cpu_stall === 1'b1)
        n++;
      @(posedge clk);
    end
  endtask

  // ****************************
  // scenarios
  // ****************************
  task automatic t_reset();
    rd(6'h1c, rv);
    chk(rv, 8'h00);
    rd(6'h1d, rv);
    chk(rv, 8'h00);
    rd(6'h00, rv);
    chk(rv, 8'h00);
    chk({6'h00, cpu_stall, ready_irq}, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_rw();
    logic [8:0] at [4] = '{9'h000, 9'h1ff, 9'h100, 9'h0ff};
    logic [7:0] dt [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      prog(at[i], dt[i], 0);
      count_stall(n);
      chk(n[7:0], 8'h02);
      wait_idle();
    end
    rd(6'h1f, rv);
    chk(rv, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      fetch(at[i], rv);
      chk(rv, dt[i]);
    end
    wr(6'h1f, 8'hff);
    rd(6'h1f, rv);
    chk(rv, 8'h01);
    wr(6'h1c, 8'h01);
    count_stall(n);
    chk(n[7:0], 8'h04);
    $display("t_rw done");
  endtask

  task automatic t_mwe();
    int n;
    wr(6'h1c, 8'h04);
    repeat (2) @(posedge clk);
    rd(6'h1c, rv);
    chk(rv, 8'h04);
    wr(6'h1c, 8'h04);
    repeat (3) @(posedge clk);
    rd(6'h1c, rv);
    chk(rv, 8'h00);
    wr(6'h1c, 8'h02);
    count_stall(n);
    chk(n[7:0], 8'h00);
    prog(9'h010, 8'h55, 2);
    wait_idle();
    fetch(9'h010, rv);
    chk(rv, 8'h55);
    prog(9'h010, 8'haa, 3);
    rd(6'h1c, rv);
    chk(rv, 8'h00);
    fetch(9'h010, rv);
    chk(rv, 8'h55);
    $display("t_mwe done");
  endtask

  task automatic t_flash();
    @(posedge clk);
    flash_selfprog_busy <= 1'b1;
    prog(9'h010, 8'h99, 0);
    rd(6'h1c, rv);
    chk(rv, 8'h00);
    @(posedge clk);
    flash_selfprog_busy <= 1'b0;
    fetch(9'h010, rv);
    chk(rv, 8'h55);
    $display("t_flash done");
  endtask

  task automatic t_busy();
    int n;
    @(posedge clk);
    global_irq_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, ready_irq}, 8'h00);
    ien = 8'h08;
    wr(6'h1c, ien);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, ready_irq}, 8'h01);
    prog(9'h020, 8'h66, 0);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, ready_irq}, 8'h00);
    // n counts edges since the edge that took the strobe
    n = 2;
    while (ready_irq !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100)
        give_up();
    end
    // completion phase and synchroniser depth give a window
    chk({7'h00, n >= (WOC - 1) * ODIV + 4}, 8'h01);
    chk({7'h00, n <= WOC * ODIV + 3}, 8'h01);
    prog(9'h021, 8'h5a, 0);
    @(posedge clk);
    #1;
    chk({7'h00, ready_irq}, 8'h00);
    wr(6'h1e, 8'h00);
    wr(6'h1c, ien | 8'h01);
    rd(6'h1e, rv);
    chk(rv, 8'h21);
    rd(6'h1d, rv);
    chk(rv, 8'h5a);
    wait_idle();
    fetch(9'h020, rv);
    chk(rv, 8'h66);
    fetch(9'h021, rv);
    chk(rv, 8'h5a);
    @(posedge clk);
    global_irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, ready_irq}, 8'h00);
    $display("t_busy done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_rw();
    t_mwe();
    t_flash();
    t_busy();
    test_done();
  end
endmodule // tb
